//--- hw/plp_defs.svh
/*
  Constants of the protection logic primitives: register offsets,
  field positions, reset values and timing counts.
  Assumes inclusion by bare name from the package and the top module.
*/
`ifndef PLP_DEFS_SVH
`define PLP_DEFS_SVH

// register byte offsets on the apb slave
`define PLP_OFS_CTRL      8'h00
`define PLP_OFS_OVER_THR  8'h04
`define PLP_OFS_UNDER_THR 8'h08
`define PLP_OFS_TON       8'h0C
`define PLP_OFS_TOFF      8'h10
`define PLP_OFS_PULSE_LEN 8'h14
`define PLP_OFS_TICK_DIV  8'h18
`define PLP_OFS_STATUS    8'h1C

// control register fields
`define PLP_CTRL_VX_SRC   0
`define PLP_CTRL_ASG_EN   1
`define PLP_CTRL_ASG_LO   2
`define PLP_CTRL_ASG_HI   4
`define PLP_CTRL_SOFT_CLR 8

// status register fields
`define PLP_ST_VX_MEAS    0
`define PLP_ST_VX_CALC    1
`define PLP_ST_EXT_BLK    2
`define PLP_ST_UNASG      3
`define PLP_ST_OVER       4
`define PLP_ST_UNDER      5
`define PLP_ST_TIMER      6
`define PLP_ST_PULSE      7
`define PLP_ST_AND        8
`define PLP_ST_OR         9
`define PLP_ST_XOR        10

// widths
`define PLP_DW            16
`define PLP_NSIG          8
`define PLP_NPIN          12

// reset values; 0.4 as an unsigned fraction of 2^16
`define PLP_OVER_THR_RST  16'h6666
`define PLP_UNDER_THR_RST 16'h0000
`define PLP_TON_RST       16'h0000
`define PLP_TOFF_RST      16'h0000
`define PLP_PULSE_LEN_RST 16'h0064

// timing: one tick per millisecond at a 25 ns clock
`define PLP_CLK_NS        25
`define PLP_TICK_NS       1000000
`define PLP_TICK_CYC      (`PLP_TICK_NS / `PLP_CLK_NS)

`endif

//--- hw/plp_pkg.sv
/*
  Types of the protection logic primitives: state encodings and the
  packed state records of the top module and the delay timer.
  Assumes plp_defs.svh is on the include path.
*/
`include "plp_defs.svh"

package plp_pkg;

  // delay timer states, one-hot
  typedef enum logic [3:0] {
    TS_IDLE     = 4'h1,
    TS_ON_WAIT  = 4'h2,
    TS_ACTIVE   = 4'h4,
    TS_OFF_WAIT = 4'h8
  } plp_tmr_state_t;

  typedef struct packed {
    plp_tmr_state_t          state;
    logic [`PLP_DW-1:0]      cnt;
    logic                    out;
  } plp_tmr_st_t;

  typedef struct packed {
    logic [`PLP_NPIN-1:0]    sync1;
    logic [`PLP_NPIN-1:0]    sync2;
    logic [`PLP_DW-1:0]      tick_cnt;
    logic                    tick;
    logic                    vx_calc;
    logic                    asg_en;
    logic [2:0]              asg_sel;
    logic [`PLP_DW-1:0]      over_thr;
    logic [`PLP_DW-1:0]      under_thr;
    logic [`PLP_DW-1:0]      ton;
    logic [`PLP_DW-1:0]      toff;
    logic [`PLP_DW-1:0]      plen;
    logic [`PLP_DW-1:0]      tick_div;
    logic                    soft_clr;
    logic [`PLP_DW-1:0]      pulse_cnt;
    logic                    trig_d;
    logic                    pulse_o;
    logic                    vx_meas_o;
    logic                    vx_calc_o;
    logic                    ext_blk_o;
    logic                    unasg_o;
    logic                    over_o;
    logic                    under_o;
    logic                    and_o;
    logic                    or_o;
    logic                    xor_o;
    logic [31:0]             prdata;
    logic                    pready;
    logic                    pslverr;
  } plp_state_t;

endpackage

//--- hw/plp_tmr_if.sv
/*
  Link between the top module and its delay timer: input level,
  delays, tick, clear and enable one way, the timer output back.
  Assumes both ends run on pclk.
*/
`timescale 1ns/1ps

`include "plp_defs.svh"

interface plp_tmr_if;
  logic                    in;
  logic [`PLP_DW-1:0]      ton;
  logic [`PLP_DW-1:0]      toff;
  logic                    tick;
  logic                    clr;
  logic                    ce;
  logic                    out;

  modport ctl (output in, ton, toff, tick, clr, ce, input out);
  modport tmr (input in, ton, toff, tick, clr, ce, output out);
endinterface

//--- hw/plp_timer.sv
/*
  Delay timer with separate switch-on and switch-off delays, counted
  in ticks. Assumes tick is a one-cycle pulse on pclk and clr a
  synchronous clear from the same domain.
*/
`timescale 1ns/1ps

module plp_timer (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // control side
  plp_tmr_if.tmr           t
);
  import plp_pkg::*;

  plp_tmr_st_t st_reg;
  plp_tmr_st_t st_next;

  // next state; an input change during either wait returns to the state before that wait
  always_comb
  begin
    st_next = st_reg;
    if (t.clr)
    begin
      st_next.state = TS_IDLE; // R11
      st_next.cnt   = '0;
      st_next.out   = 1'b0;
    end
    else
    begin
      case (st_reg.state)
        TS_IDLE:
        begin
          if (t.in)
          begin
            st_next.state = TS_ON_WAIT;
            st_next.cnt   = '0;
          end
        end
        TS_ON_WAIT:
        begin
          if (!t.in)
            st_next.state = TS_IDLE; // R7
          else if (st_reg.cnt >= t.ton)
          begin
            st_next.state = TS_ACTIVE; // R7
            st_next.out   = 1'b1;
          end
          else if (t.tick)
            st_next.cnt = st_reg.cnt + 1'b1; // R11
        end
        TS_ACTIVE:
        begin
          if (!t.in)
          begin
            st_next.state = TS_OFF_WAIT;
            st_next.cnt   = '0;
          end
        end
        TS_OFF_WAIT:
        begin
          if (t.in)
            st_next.state = TS_ACTIVE;
          else if (st_reg.cnt >= t.toff)
          begin
            st_next.state = TS_IDLE; // R8
            st_next.out   = 1'b0;
          end
          else if (t.tick)
            st_next.cnt = st_reg.cnt + 1'b1; // R8
        end
        default:
        begin
          st_next.state = TS_IDLE;
          st_next.out   = 1'b0;
        end
      endcase
    end
  end

  // clock enable low freezes the whole timer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg.state <= TS_IDLE;
      st_reg.cnt   <= '0;
      st_reg.out   <= 1'b0;
    end
    else if (t.ce)
      st_reg <= st_next;
  end

  assign t.out = st_reg.out;
endmodule

//--- hw/plp_top.sv
/*
  Protection logic primitives behind an apb slave: source selector,
  assignable input, threshold comparators, delay timer, pulse and
  gates. Assumes pins are asynchronous to pclk, analog values come
  from logic on pclk, and the apb master follows the usual protocol.
*/
// Behaviour
// R1: measured source: output one on, two off
// R2: calculated source: output one off, two on
// R3: assigned input follows its chosen binary signal
// R4: unassigned input stays off, only unassigned flag
// R5: over comparator active when value exceeds threshold
// R6: under comparator active when value below threshold
// R7: timer output on after continuous on delay
// R8: timer output off after off delay elapses
// R9: trigger gives pulse of settable length
// R10: and, or, xor with inverted second input; the code inverts gate_b only in the xor, and and or take it as it is
// R11: delays count common ticks; counters clear synchronously
`timescale 1ns/1ps
`include "plp_defs.svh"

module plp_top #(
  parameter int unsigned TICK_CYC = `PLP_TICK_CYC
) (
  // clock, reset and enable
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 ce,
  // apb slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  // binary pins, asynchronous
  input  wire logic [`PLP_NSIG-1:0] sig_in,
  input  wire logic                 timer_in,
  input  wire logic                 pulse_trig,
  input  wire logic                 gate_a,
  input  wire logic                 gate_b,
  // analog values, from logic on pclk
  input  wire logic [`PLP_DW-1:0]   ratio_value,
  input  wire logic [`PLP_DW-1:0]   phase_one_current,
  // primitive outputs
  output logic                      vx_measured_act,
  output logic                      vx_calculated_act,
  output logic                      external_block_input_one,
  output logic                      ext_block_unassigned,
  output logic                      over_act,
  output logic                      under_act,
  output logic                      timer_out,
  output logic                      pulse_module,
  output logic                      and_out,
  output logic                      or_out,
  output logic                      xor_out
);
  import plp_pkg::*;

  localparam logic [`PLP_DW-1:0] TICK_DIV_RST = `PLP_DW'(TICK_CYC - 1);

  plp_state_t s_reg;
  plp_state_t s_next;
  plp_tmr_if  tmr_if ();

  logic [`PLP_NSIG-1:0] pool;
  logic                 tmr_pin;
  logic                 trig_pin;
  logic                 ga;
  logic                 gb;
  logic                 acc;
  logic                 wr;
  logic                 tmr_q;

  // synchronised pin fields; only the second stage is read
  assign pool     = s_reg.sync2[`PLP_NSIG-1:0];
  assign tmr_pin  = s_reg.sync2[`PLP_NSIG];
  assign trig_pin = s_reg.sync2[`PLP_NSIG+1];
  assign ga       = s_reg.sync2[`PLP_NSIG+2];
  assign gb       = s_reg.sync2[`PLP_NSIG+3];

  // a transfer completes on the access edge where pready is high
  assign acc = psel & penable & s_reg.pready;
  assign wr  = acc & pwrite;

  // delay timer hookup, sharing the common tick and clear
  assign tmr_if.in   = tmr_pin;
  assign tmr_if.ton  = s_reg.ton;
  assign tmr_if.toff = s_reg.toff;
  assign tmr_if.tick = s_reg.tick; // R11
  assign tmr_if.clr  = s_reg.soft_clr; // R11
  assign tmr_if.ce   = ce;
  assign tmr_q       = tmr_if.out;

  plp_timer u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .t       (tmr_if)
  );

  // whole next state of the block
  always_comb
  begin
    s_next = s_reg;

    // two-flop synchroniser for every pin
    s_next.sync1 = {gate_b, gate_a, pulse_trig, timer_in, sig_in};
    s_next.sync2 = s_reg.sync1;

    // common tick prescaler; soft clear restarts the phase
    s_next.tick = 1'b0;
    if (s_reg.soft_clr)
      s_next.tick_cnt = '0; // R11
    else if (s_reg.tick_cnt >= s_reg.tick_div)
    begin
      s_next.tick_cnt = '0;
      s_next.tick     = 1'b1; // R11
    end
    else
      s_next.tick_cnt = s_reg.tick_cnt + 1'b1;

    // source selector outputs are exact complements
    s_next.vx_meas_o = ~s_reg.vx_calc; // R1
    s_next.vx_calc_o = s_reg.vx_calc; // R2

    // assignable input; unassigned holds it low while asg_en is clear
    s_next.ext_blk_o = s_reg.asg_en & pool[s_reg.asg_sel]; // R3 R4
    s_next.unasg_o   = ~s_reg.asg_en; // R4

    // comparators; strict, so equal to threshold reads inactive
    s_next.over_o  = ratio_value > s_reg.over_thr; // R5
    s_next.under_o = phase_one_current < s_reg.under_thr; // R6

    // gates
    s_next.and_o = ga & gb; // R10
    s_next.or_o  = ga | gb; // R10
    s_next.xor_o = ga ^ ~gb; // R10

    // pulse on a rising trigger edge; not retriggered while running
    s_next.trig_d = trig_pin;
    if (s_reg.soft_clr)
    begin
      s_next.pulse_cnt = '0; // R11
      s_next.pulse_o   = 1'b0;
    end
    else if (trig_pin && !s_reg.trig_d && !s_reg.pulse_o &&
             s_reg.plen != '0)
    begin
      s_next.pulse_cnt = s_reg.plen; // R9
      s_next.pulse_o   = 1'b1;
    end
    else if (s_reg.pulse_o && s_reg.tick)
    begin
      s_next.pulse_cnt = s_reg.pulse_cnt - 1'b1; // R9
      if (s_reg.pulse_cnt == `PLP_DW'(1))
        s_next.pulse_o = 1'b0; // R9
    end

    // soft clear is a one-cycle strobe
    s_next.soft_clr = 1'b0;

    // apb: pready rises one cycle after setup, zero wait states
    s_next.pready  = psel & ~penable;
    s_next.pslverr = 1'b0;
    s_next.prdata  = '0;
    if (psel && !penable)
    begin
      case (paddr)
        `PLP_OFS_CTRL:
          s_next.prdata = {27'h0000000, s_reg.asg_sel,
                           s_reg.asg_en, s_reg.vx_calc};
        `PLP_OFS_OVER_THR:  s_next.prdata = {16'h0000, s_reg.over_thr};
        `PLP_OFS_UNDER_THR: s_next.prdata = {16'h0000, s_reg.under_thr};
        `PLP_OFS_TON:       s_next.prdata = {16'h0000, s_reg.ton};
        `PLP_OFS_TOFF:      s_next.prdata = {16'h0000, s_reg.toff};
        `PLP_OFS_PULSE_LEN: s_next.prdata = {16'h0000, s_reg.plen};
        `PLP_OFS_TICK_DIV:  s_next.prdata = {16'h0000, s_reg.tick_div};
        `PLP_OFS_STATUS:
          s_next.prdata = {21'h000000, s_reg.xor_o, s_reg.or_o,
                           s_reg.and_o, s_reg.pulse_o, tmr_q,
                           s_reg.under_o, s_reg.over_o, s_reg.unasg_o,
                           s_reg.ext_blk_o, s_reg.vx_calc_o,
                           s_reg.vx_meas_o};
        default: s_next.pslverr = 1'b1;
      endcase
      if (pwrite && paddr == `PLP_OFS_STATUS)
        s_next.pslverr = 1'b1; // status is read-only
    end

    // register writes land on the completing access edge only
    if (wr)
    begin
      case (paddr)
        `PLP_OFS_CTRL:
        begin
          s_next.vx_calc  = pwdata[`PLP_CTRL_VX_SRC]; // R1 R2
          s_next.asg_en   = pwdata[`PLP_CTRL_ASG_EN]; // R3 R4
          s_next.asg_sel  = pwdata[`PLP_CTRL_ASG_HI:`PLP_CTRL_ASG_LO];
          s_next.soft_clr = pwdata[`PLP_CTRL_SOFT_CLR]; // R11
        end
        `PLP_OFS_OVER_THR:  s_next.over_thr  = pwdata[`PLP_DW-1:0];
        `PLP_OFS_UNDER_THR: s_next.under_thr = pwdata[`PLP_DW-1:0];
        `PLP_OFS_TON:       s_next.ton       = pwdata[`PLP_DW-1:0];
        `PLP_OFS_TOFF:      s_next.toff      = pwdata[`PLP_DW-1:0];
        `PLP_OFS_PULSE_LEN: s_next.plen      = pwdata[`PLP_DW-1:0];
        `PLP_OFS_TICK_DIV:  s_next.tick_div  = pwdata[`PLP_DW-1:0];
        default: ;
      endcase
    end
  end

  // single state register; ce low freezes everything, apb included
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_reg           <= '0;
      s_reg.over_thr  <= `PLP_OVER_THR_RST;
      s_reg.under_thr <= `PLP_UNDER_THR_RST;
      s_reg.ton       <= `PLP_TON_RST;
      s_reg.toff      <= `PLP_TOFF_RST;
      s_reg.plen      <= `PLP_PULSE_LEN_RST;
      s_reg.tick_div  <= TICK_DIV_RST;
      s_reg.vx_meas_o <= 1'b1;
      s_reg.unasg_o   <= 1'b1;
    end
    else if (ce)
      s_reg <= s_next;
  end

  // outputs straight from flip-flops
  assign prdata                   = s_reg.prdata;
  assign pready                   = s_reg.pready;
  assign pslverr                  = s_reg.pslverr;
  assign vx_measured_act          = s_reg.vx_meas_o;
  assign vx_calculated_act        = s_reg.vx_calc_o;
  assign external_block_input_one = s_reg.ext_blk_o;
  assign ext_block_unassigned     = s_reg.unasg_o;
  assign over_act                 = s_reg.over_o;
  assign under_act                = s_reg.under_o;
  assign timer_out                = tmr_q;
  assign pulse_module             = s_reg.pulse_o;
  assign and_out                  = s_reg.and_o;
  assign or_out                   = s_reg.or_o;
  assign xor_out                  = s_reg.xor_o;
endmodule

//--- test/plp_top_properties.sv
/*
  Port checker of plp_top, bound to every instance of it.
  Assumes ce is held high and apb writes follow the slave contract.
*/
`timescale 1ns/1ps
`include "plp_defs.svh"

module plp_top_properties #(
  parameter int unsigned TICK_CYC = 8
) (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  // pins and values
  input wire logic [7:0]  sig_in,
  input wire logic        timer_in,
  input wire logic        gate_a,
  input wire logic        gate_b,
  input wire logic [15:0] ratio_value,
  input wire logic [15:0] phase_one_current,
  // primitive outputs
  input wire logic        vx_measured_act,
  input wire logic        vx_calculated_act,
  input wire logic        external_block_input_one,
  input wire logic        ext_block_unassigned,
  input wire logic        over_act,
  input wire logic        under_act,
  input wire logic        timer_out,
  input wire logic        pulse_module,
  input wire logic        and_out,
  input wire logic        or_out,
  input wire logic        xor_out
);
  logic [2:0]  live;
  logic        calc;
  logic        en;
  logic [2:0]  sel;
  logic [15:0] ovr;
  logic [15:0] und;
  logic [15:0] ton;
  logic [15:0] toff;
  logic [15:0] plen;
  logic [19:0] hi;
  logic [19:0] lo;
  logic [19:0] pc;
  wire         wr = psel & penable & pready & pwrite;

  // shadow registers and run lengths; live hides the pin pipeline fill
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      {live, calc, en, sel, und, ton, toff, hi, lo, pc} <= '0;
      ovr  <= `PLP_OVER_THR_RST;
      plen <= `PLP_PULSE_LEN_RST;
    end
    else
    begin
      live <= (live == 3'h7) ? live : live + 3'h1;
      hi   <= timer_in ? hi + 20'h1 : 20'h0;
      lo   <= timer_in ? 20'h0 : lo + 20'h1;
      pc   <= pulse_module ? pc + 20'h1 : 20'h0;
      if (wr)
        case (paddr)
          `PLP_OFS_CTRL:      {sel, en, calc} <= pwdata[4:0];
          `PLP_OFS_OVER_THR:  ovr  <= pwdata[15:0];
          `PLP_OFS_UNDER_THR: und  <= pwdata[15:0];
          `PLP_OFS_TON:       ton  <= pwdata[15:0];
          `PLP_OFS_TOFF:      toff <= pwdata[15:0];
          `PLP_OFS_PULSE_LEN: plen <= pwdata[15:0];
          default:            ;
        endcase
    end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // relations between outputs and their causes
  property p_sel;
    live != 0 |-> vx_calculated_act == $past(calc)
      && vx_measured_act == !$past(calc);
  endproperty
  a_sel: assert property (p_sel) else $error("selector wrong");
  property p_asg;
    live > 2 |-> external_block_input_one == ($past(en)
      && (($past(sig_in, 3) >> $past(sel)) & 8'h01) != 8'h00);
  endproperty
  a_asg: assert property (p_asg) else $error("assign wrong");
  property p_unasg;
    live != 0 |-> ext_block_unassigned == !$past(en);
  endproperty
  a_unasg: assert property (p_unasg) else $error("unassigned");
  property p_over;
    live != 0 |-> over_act == ($past(ratio_value) > $past(ovr));
  endproperty
  a_over: assert property (p_over) else $error("over wrong");
  property p_under;
    live != 0 |-> under_act == ($past(phase_one_current) < $past(und));
  endproperty
  a_under: assert property (p_under) else $error("under wrong");
  property p_ton;
    $rose(timer_out) |-> hi + TICK_CYC >= ton * TICK_CYC;
  endproperty
  a_ton: assert property (p_ton) else $error("timer early");
  property p_toff;
    $fell(timer_out) |-> lo + TICK_CYC >= toff * TICK_CYC;
  endproperty
  a_toff: assert property (p_toff) else $error("timer drop early");
  property p_pulse;
    $fell(pulse_module) |-> pc + TICK_CYC > plen * TICK_CYC
      && pc <= plen * TICK_CYC;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse length");
  property p_gate;
    live > 2 |-> and_out == ($past(gate_a, 3) & $past(gate_b, 3))
      && or_out == ($past(gate_a, 3) | $past(gate_b, 3))
      && xor_out == ($past(gate_a, 3) ^ !$past(gate_b, 3));
  endproperty
  a_gate: assert property (p_gate) else $error("gate wrong");
  property p_rdy;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("apb answer late");

  // main scenarios reached
  c_tmr: cover property ($fell(timer_out));
  c_pls: cover property ($fell(pulse_module));
  c_ovr: cover property ($rose(over_act));
endmodule

bind plp_top plp_top_properties #(.TICK_CYC(TICK_CYC)) i_props (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .sig_in, .timer_in, .gate_a, .gate_b, .ratio_value, .phase_one_current,
  .vx_measured_act, .vx_calculated_act, .external_block_input_one,
  .ext_block_unassigned, .over_act, .under_act, .timer_out, .pulse_module,
  .and_out, .or_out, .xor_out);

//--- test/test_plp_top.sv
/*
  Self-checking bench of plp_top: registers over apb, pins, timing.
  Assumes the checker file is compiled with it; ce is held high.
*/
`timescale 1ns/1ps
`include "plp_defs.svh"

module test_plp_top;
  localparam int unsigned T = 8;
  typedef struct {logic [31:0] m; logic e; logic [31:0] d;} plp_exp_t;
  plp_exp_t    q[$];
  int          errors = 0;
  int          tests_run = 0;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [7:0]  sig_in = 8'h00;
  logic        timer_in = 1'b0;
  logic        pulse_trig = 1'b0;
  logic        gate_a = 1'b0;
  logic        gate_b = 1'b0;
  logic [15:0] ratio_value = 16'h0;
  logic [15:0] phase_one_current = 16'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, vx_measured_act, vx_calculated_act;
  logic        external_block_input_one, ext_block_unassigned, over_act;
  logic        under_act, timer_out, pulse_module, and_out, or_out, xor_out;

  plp_top #(.TICK_CYC(T)) i_dut (.ce(1'b1), .*);

  always #12.5 pclk = ~pclk;

  // one apb transfer; the expected answer is noted for the monitor
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [31:0] m,
                      input logic e);
    q.push_back('{m, e, d});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle count is assumed; only the watchdog ends a hung wait
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [31:0] m);
    xfer(1'b0, a, d, m, 1'b0);
  endtask

  task automatic wt(input bit s, input logic v, output int c);
    c = 0;
    while ((s ? pulse_module : timer_out) !== v && c < 999)
    begin
      @(posedge pclk);
      c++;
    end
  endtask

  task automatic rng(input int v, input int lo, input int hi);
    tests_run++;
    if (v < lo || v > hi)
    begin
      errors++;
      $display("CHECK FAILED t=%0t got %h exp %h..%h", $time, v, lo, hi);
    end
  endtask

  // answers are compared in the cycle that pready stands
  always @(posedge pclk)
    if (pready === 1'b1 && q.size() > 0)
    begin
      plp_exp_t x;
      x = q.pop_front();
      tests_run++;
      if ({pslverr, prdata & x.m} !== {x.e, x.d & x.m})
      begin
        errors++;
        $display("CHECK FAILED t=%0t got %h exp %h", $time,
                 {pslverr, prdata & x.m}, {x.e, x.d & x.m});
      end
    end

  task automatic complete_run;
    if (q.size() != 0)
      errors++;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // the tests need a few hundred cycles at most
  initial
  begin
    repeat (20000) @(posedge pclk);
    errors++;
    complete_run();
  end

  initial
  begin
    int          c;
    logic [15:0] o, u, r, i1;
    void'($urandom(28788));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // reset values, unmapped and read-only places
    rd(`PLP_OFS_CTRL, 32'h0, '1);
    rd(`PLP_OFS_OVER_THR, 32'h6666, '1);
    rd(`PLP_OFS_UNDER_THR, 32'h0, '1);
    rd(`PLP_OFS_TON, 32'h0, '1);
    rd(`PLP_OFS_PULSE_LEN, 32'h64, '1);
    rd(`PLP_OFS_TICK_DIV, T - 1, '1);
    xfer(1'b0, 8'h20, 32'h0, '1, 1'b1);
    xfer(1'b1, `PLP_OFS_STATUS, 32'h0, 32'h0, 1'b1);
    rd(`PLP_OFS_STATUS, 32'h409, '1);
    xfer(1'b1, `PLP_OFS_CTRL, 32'h1, 32'h0, 1'b0);
    rd(`PLP_OFS_STATUS, 32'h2, 32'h3);
    // every pool index, random pin levels
    for (int i = 0; i < 8; i++)
    begin
      sig_in <= 8'($urandom);
      xfer(1'b1, `PLP_OFS_CTRL, 32'(i * 4 + 2), 32'h0, 1'b0);
      rd(`PLP_OFS_STATUS, {29'h0, sig_in[i], 2'b01}, 32'hF);
    end
    xfer(1'b1, `PLP_OFS_CTRL, 32'h100, 32'h0, 1'b0);
    rd(`PLP_OFS_STATUS, 32'h9, 32'hF);
    rd(`PLP_OFS_CTRL, 32'h0, '1);
    // comparators, the first pass at the equal boundary
    o = 16'($urandom);
    u = 16'($urandom);
    xfer(1'b1, `PLP_OFS_OVER_THR, {16'h0, o}, 32'h0, 1'b0);
    xfer(1'b1, `PLP_OFS_UNDER_THR, {16'h0, u}, 32'h0, 1'b0);
    for (int k = 0; k < 6; k++)
    begin
      r = (k == 0) ? o : 16'($urandom);
      i1 = (k == 0) ? u : 16'($urandom);
      ratio_value <= r;
      phase_one_current <= i1;
      // one edge so the comparator flops hold the new values at setup
      @(posedge pclk);
      rd(`PLP_OFS_STATUS, {26'h0, i1 < u, r > o, 4'h0}, 32'h30);
    end
    // all gate input pairs
    for (int g = 0; g < 4; g++)
    begin
      gate_a <= g[0];
      gate_b <= g[1];
      repeat (3) @(posedge pclk);
      rd(`PLP_OFS_STATUS, {21'h0, gate_a ^ !gate_b, gate_a | gate_b,
         gate_a & gate_b, 8'h0}, 32'h700);
    end
    // delay timer in both directions
    xfer(1'b1, `PLP_OFS_TON, 32'h3, 32'h0, 1'b0);
    xfer(1'b1, `PLP_OFS_TOFF, 32'h2, 32'h0, 1'b0);
    // a high spell shorter than the on delay must not switch on
    timer_in <= 1'b1;
    repeat (T) @(posedge pclk);
    timer_in <= 1'b0;
    repeat (3 * T) @(posedge pclk);
    rd(`PLP_OFS_STATUS, 32'h0, 32'h40);
    timer_in <= 1'b1;
    wt(1'b0, 1'b1, c);
    rng(c, 2 * T, 3 * T + 5);
    timer_in <= 1'b0;
    wt(1'b0, 1'b0, c);
    rng(c, T, 2 * T + 5);
    // pulse of two ticks
    xfer(1'b1, `PLP_OFS_PULSE_LEN, 32'h2, 32'h0, 1'b0);
    pulse_trig <= 1'b1;
    wt(1'b1, 1'b1, c);
    rng(c, 2, 5);
    pulse_trig <= 1'b0;
    wt(1'b1, 1'b0, c);
    rng(c, T, 2 * T + 1);
    complete_run();
  end
endmodule
